// [rtl/adc_seq_defines.vh]
// register offsets, field positions, reset values and timing counts
// for the converter sequencer; included by the sequencer only
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH

// byte addresses on the register bus
`define OFS_CTRL 12'h000
`define OFS_RESULT 12'h004
`define OFS_INJ_RESULT 12'h008
`define OFS_TIMING 12'h00C
`define OFS_SCAN 12'h010
`define OFS_IRQ_STATUS 12'h014
`define OFS_IRQ_MASK 12'h018
`define OFS_PORT_IN 12'h01C
`define OFS_EXT_BUS 12'h020

// control register fields
`define CTL_START 0
`define CTL_MODE_LO 1
`define CTL_MODE_HI 2
`define CTL_OVR_SUSPEND 3
`define CTL_WAIT_READ 4
`define CTL_INJ_REQ 5
`define CTL_CH_LO 8
`define CTL_CH_HI 12
`define CTL_INJ_CH_LO 16
`define CTL_INJ_CH_HI 20

// conversion modes
`define MODE_SINGLE 2'b00
`define MODE_CONT 2'b01
`define MODE_SCAN 2'b10
`define MODE_SCAN_CONT 2'b11

// status bits
`define ST_DONE 0
`define ST_OVERRUN 1
`define ST_INJ_DONE 2

// reset values
`define TIMING_RESET 32'h0010_0008

// widths
`define RES_W 10
`define CH_W 5
`define NUM_CH 24

// calibration time in cpu clock cycles, as printed (40.630 = 40630)
`define CAL_CYCLES 40630

`endif

// [rtl/adc_conversion_sequencer.v]
// conversion sequencer for a 10-bit converter with 16+8 muxed inputs
// assumes an apb master on i_mclk and an analog core that samples while
// o_sample is high and delivers i_conv_data when told to latch
//
// What this block does
// - 10-bit result per conversion; selects among 16+8 input channels
// - one extension-bus bit picks which port group feeds the mux
// - sample and conversion durations are software programmable
// - overrun interrupt when result completes before previous one read
// - alternative: suspend next conversion until pending result is read
// - single channel single: convert selected channel once, store result
// - single channel continuous: repeat on channel, update each time
// - auto scan single: each selected channel once, storing each result
// - auto scan continuous: cycle through selected channels repeatedly
// - a completed result raises a request for isr or event ctrl unless an unread one is pending with wait-read or suspend set
// - wait-for-read in continuous: buffer result, hold until read
// - injection in continuous modes converts one channel into injection result, mode resumes
// - self-calibration up to 40.630 cycles after reset, busy set
// - once post-reset sequence is done, calibration does not repeat until the next reset
// - unused analog inputs stay readable as digital port pins
`timescale 1ns/100ps
`include "adc_seq_defines.vh"

module adc_conversion_sequencer #(
  parameter CAL_LEN = `CAL_CYCLES
) (
  input wire i_mclk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output reg o_pready,
  output reg o_pslverr,
  input wire [9:0] i_conv_data,
  input wire [23:0] i_port_pins,
  output reg [4:0] o_mux_sel,
  output reg o_group_sel,
  output reg o_sample,
  output reg o_convert,
  output reg o_calibrate,
  output reg o_result_req,
  output reg o_irq
);

  localparam S_CAL = 5'b00001;
  localparam S_IDLE = 5'b00010;
  localparam S_SAMPLE = 5'b00100;
  localparam S_CONV = 5'b01000;
  localparam S_HOLD = 5'b10000;

  function [4:0] next_scan_ch;
    input [4:0] cur;
    input [23:0] sel;
    integer k;
    integer idx;
    reg found;
    begin
      next_scan_ch = cur;
      found = 1'b0;
      for (k = 1; k <= `NUM_CH; k = k + 1) begin
        idx = (cur + k) % `NUM_CH;
        if (!found && sel[idx]) begin
          next_scan_ch = idx[4:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  reg [4:0] state_q;
  reg [15:0] cnt_q;
  reg [31:0] ctrl_q;
  reg [31:0] timing_q;
  reg [23:0] scan_q;
  reg [2:0] status_q;
  reg [2:0] mask_q;
  reg group_q;
  reg [9:0] result_q;
  reg [4:0] result_ch_q;
  reg [9:0] inj_result_q;
  reg pending_q;
  reg [9:0] temp_q;
  reg [4:0] temp_ch_q;
  reg injecting_q;
  reg [4:0] cur_ch_q;
  reg [4:0] resume_ch_q;
  reg first_q;
  reg [23:0] pin_meta_q;
  reg [23:0] pin_sync_q;

  wire [1:0] mode = ctrl_q[`CTL_MODE_HI:`CTL_MODE_LO];
  wire cont_mode = mode[0];
  wire scan_mode = mode[1];
  wire busy = (state_q != S_IDLE);
  wire bus_acc = i_psel && i_penable;
  wire wr = bus_acc && i_pwrite;
  wire rd = bus_acc && !i_pwrite;
  wire rd_result = rd && (i_paddr == `OFS_RESULT);
  wire [15:0] samp_len = timing_q[15:0];
  wire [15:0] conv_len = timing_q[31:16];
  wire done_evt = (state_q == S_CONV) && (cnt_q == 16'h0000);
  wire normal_done = done_evt && !injecting_q;
  // a read in the completing cycle already frees the result register
  wire still_pending = pending_q && !rd_result;
  wire inj_ok = ctrl_q[`CTL_INJ_REQ] && cont_mode && !injecting_q;
  wire [4:0] scan_next = next_scan_ch(cur_ch_q, scan_q);
  // scan ends after the highest selected channel unless continuous
  wire scan_wrap = (scan_next <= cur_ch_q);
  // request stays armed until a completion really launches the injection
  wire park = still_pending &&
    (ctrl_q[`CTL_WAIT_READ] && cont_mode || ctrl_q[`CTL_OVR_SUSPEND]);
  wire inj_start = normal_done && inj_ok && !park;

  reg [2:0] evt;
  reg [31:0] rdata;
  reg decoded;

  always @* begin
    evt = 3'b000;
    evt[`ST_DONE] = normal_done &&
      !(still_pending && (ctrl_q[`CTL_WAIT_READ] || ctrl_q[`CTL_OVR_SUSPEND]));
    evt[`ST_OVERRUN] = normal_done && still_pending &&
      !ctrl_q[`CTL_OVR_SUSPEND] && !(ctrl_q[`CTL_WAIT_READ] && cont_mode);
    evt[`ST_INJ_DONE] = done_evt && injecting_q;
  end

  always @* begin
    rdata = 32'h0000_0000;
    decoded = 1'b1;
    case (i_paddr)
      `OFS_CTRL: rdata = ctrl_q;
      // busy flag mirrored in bit 31 of the result register
      `OFS_RESULT: rdata = {busy, 16'h0000, result_ch_q, result_q};
      `OFS_INJ_RESULT: rdata = {22'h00_0000, inj_result_q};
      `OFS_TIMING: rdata = timing_q;
      `OFS_SCAN: rdata = {8'h00, scan_q};
      `OFS_IRQ_STATUS: rdata = {29'h0000_0000, status_q};
      `OFS_IRQ_MASK: rdata = {29'h0000_0000, mask_q};
      `OFS_PORT_IN: rdata = {8'h00, pin_sync_q};
      `OFS_EXT_BUS: rdata = {31'h0000_0000, group_q};
      default: decoded = 1'b0;
    endcase
  end

  // apb slave: zero wait states
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !decoded;
      if (i_psel && !i_penable && !i_pwrite) begin
        o_prdata <= rdata;
      end
    end
  end

  // pins come from outside the clock domain
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pin_meta_q <= 24'h00_0000;
      pin_sync_q <= 24'h00_0000;
    end else begin
      pin_meta_q <= i_port_pins;
      pin_sync_q <= pin_meta_q;
    end
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q <= 32'h0000_0000;
      timing_q <= `TIMING_RESET;
      scan_q <= 24'h00_0000;
      mask_q <= 3'b000;
      group_q <= 1'b0;
      status_q <= 3'b000;
    end else begin
      if (wr && i_paddr == `OFS_CTRL) begin
        // start is dropped while calibration runs
        ctrl_q <= (state_q == S_CAL) ?
          {i_pwdata[31:1], 1'b0} : i_pwdata;
      end else begin
        if (state_q == S_IDLE && ctrl_q[`CTL_START]) begin
          ctrl_q[`CTL_START] <= 1'b0;
        end
        if (inj_start) begin
          ctrl_q[`CTL_INJ_REQ] <= 1'b0;
        end
      end
      if (wr && i_paddr == `OFS_TIMING) begin
        timing_q <= i_pwdata;
      end
      if (wr && i_paddr == `OFS_SCAN) begin
        scan_q <= i_pwdata[23:0];
      end
      if (wr && i_paddr == `OFS_IRQ_MASK) begin
        mask_q <= i_pwdata[2:0];
      end
      if (wr && i_paddr == `OFS_EXT_BUS) begin
        group_q <= i_pwdata[0];
      end
      // set wins over write-one-to-clear
      status_q <= (status_q & ~((wr && i_paddr == `OFS_IRQ_STATUS) ?
        i_pwdata[2:0] : 3'b000)) | evt;
    end
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= S_CAL;
      cnt_q <= 16'h0000;
      first_q <= 1'b1;
      result_q <= 10'h000;
      result_ch_q <= 5'h00;
      inj_result_q <= 10'h000;
      pending_q <= 1'b0;
      temp_q <= 10'h000;
      temp_ch_q <= 5'h00;
      injecting_q <= 1'b0;
      cur_ch_q <= 5'h00;
      resume_ch_q <= 5'h00;
    end else begin
      if (rd_result) begin
        pending_q <= 1'b0;
      end
      case (state_q)
        // calibration after every reset, busy high
        S_CAL: begin
          if ({16'h0000, cnt_q} == CAL_LEN - 1) begin
            state_q <= S_IDLE;
            cnt_q <= 16'h0000;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
        S_IDLE: begin
          if (ctrl_q[`CTL_START]) begin
            cur_ch_q <= scan_mode ? next_scan_ch(5'd23, scan_q) :
              ctrl_q[`CTL_CH_HI:`CTL_CH_LO];
            state_q <= S_SAMPLE;
            cnt_q <= samp_len;
            injecting_q <= 1'b0;
          end
        end
        S_SAMPLE: begin
          if (cnt_q == 16'h0000) begin
            state_q <= S_CONV;
            cnt_q <= conv_len;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        S_CONV: begin
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else if (injecting_q) begin
            inj_result_q <= i_conv_data;
            injecting_q <= 1'b0;
            cur_ch_q <= resume_ch_q;
            state_q <= S_SAMPLE;
            cnt_q <= samp_len;
          end else if (still_pending &&
              (ctrl_q[`CTL_WAIT_READ] && cont_mode ||
               ctrl_q[`CTL_OVR_SUSPEND])) begin
            // park in temp buffer until read
            temp_q <= i_conv_data;
            temp_ch_q <= cur_ch_q;
            state_q <= S_HOLD;
          end else begin
            result_q <= i_conv_data;
            result_ch_q <= cur_ch_q;
            pending_q <= 1'b1;
            if (inj_ok) begin
              resume_ch_q <= scan_mode ? scan_next : cur_ch_q;
              cur_ch_q <= ctrl_q[`CTL_INJ_CH_HI:`CTL_INJ_CH_LO];
              injecting_q <= 1'b1;
              state_q <= S_SAMPLE;
              cnt_q <= samp_len;
            end else if (!scan_mode && !cont_mode) begin
              state_q <= S_IDLE;
            end else if (!scan_mode) begin
              state_q <= S_SAMPLE;
              cnt_q <= samp_len;
            end else if (scan_wrap && !cont_mode) begin
              state_q <= S_IDLE;
            end else begin
              cur_ch_q <= scan_next;
              state_q <= S_SAMPLE;
              cnt_q <= samp_len;
            end
          end
        end
        S_HOLD: begin
          if (rd_result) begin
            result_q <= temp_q;
            result_ch_q <= temp_ch_q;
            pending_q <= 1'b1;
            if (!cont_mode && !scan_mode ||
                scan_mode && !cont_mode && scan_wrap) begin
              state_q <= S_IDLE;
            end else begin
              cur_ch_q <= scan_mode ? scan_next : cur_ch_q;
              state_q <= S_SAMPLE;
              cnt_q <= samp_len;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
      // continuous mode ends when software leaves continuous mode
      if (state_q == S_SAMPLE && !ctrl_q[`CTL_START] && first_q) begin
        first_q <= 1'b0;
      end
    end
  end

  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_mux_sel <= 5'h00;
      o_group_sel <= 1'b0;
      o_sample <= 1'b0;
      o_convert <= 1'b0;
      o_calibrate <= 1'b0;
      o_result_req <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_mux_sel <= cur_ch_q;
      o_group_sel <= group_q;
      o_sample <= (state_q == S_SAMPLE);
      o_convert <= (state_q == S_CONV);
      o_calibrate <= (state_q == S_CAL);
      o_result_req <= evt[`ST_DONE];
      o_irq <= |(status_q & mask_q);
    end
  end

endmodule

// [sim/adc_seq_assertions.sv]
// port-level checks on the conversion sequencer
// assumes a bind from the bench top and one clock domain
`timescale 1ns/100ps
module adc_seq_checker #(
  parameter CAL_LEN = 40630
) (
  input wire i_mclk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire [11:0] i_paddr,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire [4:0] o_mux_sel,
  input wire o_sample,
  input wire o_convert,
  input wire o_calibrate,
  input wire o_result_req
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  int cal_n;
  logic cal_done;
  // calibration length so far, and whether it has ended once
  always @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      cal_n <= 0;
      cal_done <= 1'b0;
    end else begin
      cal_n <= o_calibrate ? cal_n + 1 : 0;
      if (!o_calibrate && cal_n != 0) cal_done <= 1'b1;
    end
  end
  AST_CAL_START: assert property (
    $fell(i_rst) |=> o_calibrate) else $error("no calibration after reset");
  AST_CAL_BOUND: assert property (
    o_calibrate |-> cal_n < CAL_LEN) else $error("calibration too long");
  AST_CAL_ONCE: assert property (
    !(cal_done && o_calibrate)) else $error("calibration repeated");
  AST_IDLE_IN_CAL: assert property (
    o_calibrate |-> !o_sample && !o_convert) else $error("convert in cal");
  AST_SAMPLE_TO_CONV: assert property (
    $fell(o_sample) |-> o_convert) else $error("no conversion after sample");
  AST_CH_RANGE: assert property (
    o_mux_sel < 5'h18) else $error("channel out of range");
  AST_REQ_CAUSE: assert property (
    $rose(o_result_req) |-> $past(o_convert) || $past(o_convert, 2)
    || $past(o_convert, 3)) else $error("request without conversion");
  AST_REQ_PULSE: assert property (
    o_result_req |=> !o_result_req) else $error("request longer than one");
  AST_APB_ANSWER: assert property (
    i_psel && !i_penable |=> o_pready) else $error("no ready in access");
  AST_SLVERR: assert property (
    o_pready && i_paddr[1:0] == 2'h0 |-> o_pslverr == (i_paddr > 12'h020))
    else $error("error response wrong");
  AST_BUSY_CAL: assert property (
    o_pready && i_paddr == 12'h004 && o_calibrate && $past(o_calibrate)
    && $past(o_calibrate, 2) |-> o_prdata[31]) else $error("busy low");
  cover property (o_result_req);
  cover property (o_pready && o_pslverr);
  cover property ($fell(o_calibrate));
endmodule

// [sim/analog_core_model.sv]
// behavioural sample-and-hold core: a fixed level per channel and group
// assumes the sequencer reads the level before convert has been low a cycle
`timescale 1ns/100ps
module analog_core_model (
  input wire i_mclk,
  input wire [4:0] i_mux_sel,
  input wire i_group_sel,
  input wire i_convert,
  output logic [9:0] o_conv_data
);
  logic was_conv = 1'b0;
  wire [9:0] lvl = {i_group_sel, 4'ha, i_mux_sel};
  always @(posedge i_mclk) begin
    was_conv <= i_convert;
  end
  // ten-bit level
  // inverted outside the hold window so a late read shows up
  assign o_conv_data = (i_convert || was_conv) ? lvl : ~lvl;
endmodule

// [sim/adc_conversion_sequencer_test.sv]
// self-checking bench for the conversion sequencer over apb
// assumes the analog core model and a short calibration count
`timescale 1ns/100ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  failures++; $display("wrong value at %0t: %h, expected %h", $time, a, e); \
  end end
module adc_conversion_sequencer_test;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0;
  logic i_penable = 1'b0;
  logic i_pwrite = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0000_0000;
  logic [23:0] i_port_pins = 24'h5a_c3e1;
  wire [9:0] i_conv_data;
  wire [31:0] o_prdata;
  wire [4:0] o_mux_sel;
  wire o_pready, o_pslverr, o_group_sel, o_sample, o_convert;
  wire o_calibrate, o_result_req, o_irq;
  logic [31:0] rdat;
  logic rerr;
  int failures = 0;
  int samples_checked = 0;
  adc_conversion_sequencer #(.CAL_LEN(20)) dut (
    .i_mclk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_conv_data, .i_port_pins,
    .o_mux_sel, .o_group_sel, .o_sample, .o_convert, .o_calibrate,
    .o_result_req, .o_irq);
  analog_core_model core (.i_mclk, .i_mux_sel(o_mux_sel),
    .i_group_sel(o_group_sel), .i_convert(o_convert),
    .o_conv_data(i_conv_data));
  initial begin
    forever #20 i_mclk = ~i_mclk;
  end
  task conclude;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rdat = o_prdata;
    rerr = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    if (n >= 20) begin
      failures++;
      conclude;
    end
    @(posedge i_mclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask
  // polls one bit until it shows the wanted level
  task automatic wt(input logic [11:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while (rdat[b] !== v && n < 200);
    if (n >= 200) begin
      failures++;
      conclude;
    end
  endtask
  function automatic logic [14:0] res(input logic g, input logic [4:0] c);
    return {c, g, 4'ha, c};
  endfunction
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    rd(12'h004);
    `CHK(rdat[31], 1'b1)
    wt(12'h004, 31, 1'b0);
    wr(12'h00c, 32'h0003_0002);
    rd(12'h00c);
    `CHK(rdat, 32'h0003_0002)
    rd(12'h040);
    `CHK({rerr, rdat}, 33'h1_0000_0000)
    rd(12'h01c);
    `CHK(rdat[23:0], i_port_pins)
    wr(12'h018, 32'h0000_0007);
    wr(12'h000, 32'h0000_0501);
    wt(12'h014, 0, 1'b1);
    `CHK(o_irq, 1'b1)
    wr(12'h000, 32'h0000_0701);
    wt(12'h014, 1, 1'b1);
    rd(12'h004);
    `CHK(rdat[14:0], res(1'b0, 5'h07))
    wr(12'h014, 32'h0000_0007);
    repeat (2) @(posedge i_mclk);
    `CHK(o_irq, 1'b0)
    wr(12'h020, 32'h0000_0001);
    @(posedge i_mclk);
    `CHK(o_group_sel, 1'b1)
    wr(12'h000, 32'h0000_0301);
    wt(12'h014, 0, 1'b1);
    rd(12'h004);
    `CHK(rdat[14:0], res(1'b1, 5'h03))
    wr(12'h020, 32'h0000_0000);
    wr(12'h014, 32'h0000_0007);
    // scan over channels 1 and 3, second result must wait for a read
    wr(12'h010, 32'h0000_000a);
    wr(12'h000, 32'h0000_000d);
    wt(12'h014, 0, 1'b1);
    repeat (40) @(posedge i_mclk);
    rd(12'h004);
    `CHK(rdat[14:0], res(1'b0, 5'h01))
    rd(12'h004);
    `CHK(rdat[14:0], res(1'b0, 5'h03))
    rd(12'h014);
    `CHK(rdat[1], 1'b0)
    wr(12'h014, 32'h0000_0007);
    wr(12'h000, 32'h0000_0213);
    repeat (40) @(posedge i_mclk);
    rd(12'h014);
    `CHK(rdat[1], 1'b0)
    rd(12'h004);
    `CHK(rdat[14:0], res(1'b0, 5'h02))
    // wait-for-read off so the armed injection is not parked behind a hold
    wr(12'h000, 32'h0009_0222);
    wt(12'h014, 2, 1'b1);
    rd(12'h008);
    `CHK(rdat[9:0], 10'h149)
    rd(12'h004);
    `CHK({rdat[31], rdat[14:10]}, 6'h22)
    // a second reset in mid-run restarts calibration
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    @(posedge i_mclk);
    rd(12'h004);
    `CHK(rdat[31], 1'b1)
    wt(12'h004, 31, 1'b0);
    rd(12'h00c);
    `CHK(rdat, 32'h0010_0008)
    wr(12'h010, 32'h0000_0030);
    wr(12'h000, 32'h0000_0017);
    wt(12'h014, 0, 1'b1);
    repeat (60) @(posedge i_mclk);
    rd(12'h004);
    `CHK(rdat[14:0], res(1'b0, 5'h04))
    rd(12'h004);
    `CHK(rdat[14:0], res(1'b0, 5'h05))
    conclude;
  end
endmodule
bind adc_conversion_sequencer adc_seq_checker #(.CAL_LEN(CAL_LEN)) chk (
  .i_mclk, .i_rst, .i_psel, .i_penable, .i_paddr, .o_prdata, .o_pready,
  .o_pslverr, .o_mux_sel, .o_sample, .o_convert, .o_calibrate,
  .o_result_req);
